// File: hw/dcit_pkg.sv
// Purpose: Shared constants and types for the dual cascadable interval timer
// Assumes: APB slave with a 12-bit byte address and 32-bit data
// Notes:   Each register sits in the low byte of one aligned word

package dcit_pkg;

	// Counter and bus widths
	localparam int unsigned CNT_W    = 8;
	localparam int unsigned ADDR_W   = 12;
	localparam int unsigned DATA_W   = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_CNT1 = 12'h004;
	localparam logic [11:0] OFS_CNT2 = 12'h008;
	localparam logic [11:0] OFS_FLAG = 12'h00c;
	localparam logic [11:0] OFS_IEN  = 12'h010;

	// Field positions in the flag and enable registers
	localparam int unsigned FLAG_BIT = 7;
	localparam int unsigned IEN_BIT  = 7;

	// Reset values and the full count
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [7:0]  CNT_RST  = 8'h00;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	localparam logic [7:0]  CNT_FULL = 8'hff;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       ssel;
		logic       hold;
		logic       div;
		logic [1:0] frfq;
		logic [2:0] ip;
	} dcit_ctrl_t;

	// Register selected by an address
	typedef enum logic [2:0] {
		SEL_NONE = 3'd0,
		SEL_CTRL = 3'd1,
		SEL_CNT1 = 3'd2,
		SEL_CNT2 = 3'd3,
		SEL_FLAG = 3'd4,
		SEL_IEN  = 3'd5
	} dcit_sel_t;

	// Bus slave phase, Gray coded
	typedef enum logic {
		APB_IDLE   = 1'b0,
		APB_ACCESS = 1'b1
	} dcit_apb_st_t;

endpackage

// File: hw/dcit_sync_edge.sv
// Purpose: Bring a foreign clock pin into clock_i and flag its rising edge
// Assumes: Pin toggles slower than half of clock_i
// Notes:   Stage one feeds stage two only

`timescale 1ns/10ps

module dcit_sync_edge (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rst_i,
	// Pin and edge
	input  wire logic pin_i,
	output logic      rise_o
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} dcit_sync_state_t;

	dcit_sync_state_t state_reg;
	dcit_sync_state_t state_next;

	always_comb begin
		state_next      = state_reg;
		state_next.s1   = pin_i;
		state_next.s2   = state_reg.s1;
		state_next.s3   = state_reg.s2;
		state_next.rise = state_reg.s2 & ~state_reg.s3;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rise_o = state_reg.rise;

endmodule // dcit_sync_edge

// File: hw/dcit_counter.sv
// Purpose: Loadable wrapping up-counter
// Assumes: Load and increment are single-cycle strobes
// Notes:   A load beats an increment in the same cycle

`timescale 1ns/10ps

module dcit_counter #(
	parameter int unsigned WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	// Control
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] load_value_i,
	input  wire logic             inc_i,
	// Value
	output logic      [WIDTH-1:0] count_o
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
	} dcit_cnt_state_t;

	dcit_cnt_state_t state_reg;
	dcit_cnt_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (load_i) begin
			state_next.count = load_value_i;
		end else if (inc_i) begin
			// All ones rolls over to zero
			state_next.count = state_reg.count + 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign count_o = state_reg.count;

endmodule // dcit_counter

// File: hw/dcit_timer.sv
// Purpose: Two 8-bit interval counters, cascadable, with APB registers
// Assumes: aux and subsystem clocks are pins, slower than clock_i / 2
// Notes:   Counters advance on synchronised rising edges of their source

`timescale 1ns/10ps

module dcit_timer
	import dcit_pkg::*;
(
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [DATA_W-1:0] pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic      [DATA_W-1:0] prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// Counter clock pins
	input  wire logic              aux_clock_i,
	input  wire logic              subsystem_clock_i,
	// Processor interrupt side
	input  wire logic              global_irq_enable_i,
	input  wire logic              irq_serviced_i,
	output logic                   interval_flag_o,
	output logic                   interval_irq_o,
	// LCD controller side
	output logic                   lcd_frame_tick_o
);

	typedef struct packed {
		dcit_apb_st_t      apb_st;
		dcit_ctrl_t        ctrl;
		logic              flag;
		logic              ien;
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
		logic              irq;
		logic              tick;
	} dcit_state_t;

	dcit_state_t state_reg;
	dcit_state_t state_next;

	logic             aclk_rise;
	logic             sclk_rise;
	logic [CNT_W-1:0] cnt1;
	logic [CNT_W-1:0] cnt2;
	logic             inc1;
	logic             inc2;
	logic             casc_pulse;
	logic             src2_edge;
	logic             wr_access;
	logic             wr_lane0;
	dcit_sel_t        wr_sel;
	logic             wr1;
	logic             wr2;
	logic             interval_evt;
	logic             frame_evt;
	logic [2:0]       frame_tap;

	// Address decode, shared by the read and write paths
	function automatic dcit_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
		dcit_sel_t s;
		s = SEL_NONE;
		if (addr == OFS_CTRL) begin
			s = SEL_CTRL;
		end else if (addr == OFS_CNT1) begin
			s = SEL_CNT1;
		end else if (addr == OFS_CNT2) begin
			s = SEL_CNT2;
		end else if (addr == OFS_FLAG) begin
			s = SEL_FLAG;
		end else if (addr == OFS_IEN) begin
			s = SEL_IEN;
		end
		return s;
	endfunction

	// True when bits tap..0 are all ones, so the next increment carries out
	function automatic logic carry_at(input logic [CNT_W-1:0] v,
	                                  input logic [2:0] tap);
		logic [CNT_W-1:0] m;
		m = CNT_FULL >> (3'd7 - tap);
		return &(v | ~m);
	endfunction

	dcit_sync_edge u_aux_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (aux_clock_i),
		.rise_o  (aclk_rise)
	);

	dcit_sync_edge u_sub_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.pin_i   (subsystem_clock_i),
		.rise_o  (sclk_rise)
	);

	// Write strobe at the access edge; only byte lane 0 carries data
	assign wr_access = psel_i & penable_i & pwrite_i & state_reg.pready;
	assign wr_lane0  = wr_access & pstrb_i[0];
	assign wr_sel    = reg_sel(paddr_i);
	assign wr1       = wr_lane0 & (wr_sel == SEL_CNT1);
	assign wr2       = wr_lane0 & (wr_sel == SEL_CNT2);

	// First counter runs from aux edges unless held in cascade mode
	assign inc1 = aclk_rise
	            & ~(state_reg.ctrl.hold & state_reg.ctrl.div);

	// A wrap of the first counter is the aux/256 clock
	assign casc_pulse = inc1 & (cnt1 == CNT_FULL);

	always_comb begin
		case ({state_reg.ctrl.ssel, state_reg.ctrl.div})
		2'b00: begin
			src2_edge = aclk_rise;
		end
		2'b10: begin
			src2_edge = sclk_rise;
		end
		default: begin
			src2_edge = casc_pulse;
		end
		endcase
	end

	assign inc2 = src2_edge & ~state_reg.ctrl.hold;

	// Interval: the selected second-counter bit falls on this increment
	assign interval_evt = inc2 & carry_at(cnt2, state_reg.ctrl.ip);

	// Tap 7,6,5,4 gives aux/256,/128,/64,/32
	assign frame_tap = {1'b1, ~state_reg.ctrl.frfq};
	assign frame_evt = inc1 & carry_at(cnt1, frame_tap);

	// A software load wins over a counting edge in the same cycle
	dcit_counter #(
		.WIDTH (CNT_W)
	) u_cnt1 (
		.clock_i      (clock_i),
		.rst_i        (rst_i),
		.load_i       (wr1),
		.load_value_i (pwdata_i[CNT_W-1:0]),
		.inc_i        (inc1),
		.count_o      (cnt1)
	);

	dcit_counter #(
		.WIDTH (CNT_W)
	) u_cnt2 (
		.clock_i      (clock_i),
		.rst_i        (rst_i),
		.load_i       (wr2),
		.load_value_i (pwdata_i[CNT_W-1:0]),
		.inc_i        (inc2),
		.count_o      (cnt2)
	);

	always_comb begin
		dcit_sel_t rsel;
		rsel = reg_sel(paddr_i);
		state_next = state_reg;

		// Bus phase: answer one cycle after setup, no wait states
		state_next.pready  = 1'b0;
		state_next.pslverr = 1'b0;
		case (state_reg.apb_st)
		APB_IDLE: begin
			if (psel_i && !penable_i) begin
				state_next.apb_st  = APB_ACCESS;
				state_next.pready  = 1'b1;
				state_next.pslverr = (rsel == SEL_NONE);
				// Sampled at setup; a counter step during the access cycle is not seen
				state_next.prdata  = RDATA_RST;
				if (!pwrite_i) begin
					if (rsel == SEL_CTRL) begin
						state_next.prdata[7:0] = state_reg.ctrl;
					end else if (rsel == SEL_CNT1) begin
						state_next.prdata[7:0] = cnt1;
					end else if (rsel == SEL_CNT2) begin
						state_next.prdata[7:0] = cnt2;
					end else if (rsel == SEL_FLAG) begin
						state_next.prdata[FLAG_BIT] = state_reg.flag;
					end else if (rsel == SEL_IEN) begin
						state_next.prdata[IEN_BIT] = state_reg.ien;
					end
				end
			end
		end
		default: begin
			state_next.apb_st = APB_IDLE;
		end
		endcase

		// Control is unprogrammed until software writes it
		if (wr_lane0 && wr_sel == SEL_CTRL) begin
			state_next.ctrl = dcit_ctrl_t'(pwdata_i[7:0]);
		end
		if (wr_lane0 && wr_sel == SEL_IEN) begin
			state_next.ien = pwdata_i[IEN_BIT];
		end

		// Clear by service or by a software write; a new interval wins
		if (irq_serviced_i) begin
			state_next.flag = 1'b0;
		end
		if (wr_lane0 && wr_sel == SEL_FLAG) begin
			state_next.flag = pwdata_i[FLAG_BIT];
		end
		if (interval_evt) begin
			state_next.flag = 1'b1;
		end

		state_next.irq = state_next.flag & state_next.ien
		               & global_irq_enable_i;
		state_next.tick = frame_evt;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg         <= '0;
			state_reg.apb_st  <= APB_IDLE;
			state_reg.ctrl    <= dcit_ctrl_t'(CTRL_RST);
			state_reg.prdata  <= RDATA_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata_o         = state_reg.prdata;
	assign pready_o         = state_reg.pready;
	assign pslverr_o        = state_reg.pslverr;
	assign interval_flag_o  = state_reg.flag;
	assign interval_irq_o   = state_reg.irq;
	assign lcd_frame_tick_o = state_reg.tick;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	AST_CNT1_STEP: assert property (
		aclk_rise && !(state_reg.ctrl.hold && state_reg.ctrl.div) && !wr1
		|=> cnt1 == 8'($past(cnt1) + 8'd1))
		else $error("first counter missed an aux edge");

	AST_CNT1_HOLD: assert property (
		state_reg.ctrl.hold && state_reg.ctrl.div && !wr1
		|=> $stable(cnt1))
		else $error("first counter moved while held");

	AST_CNT2_SUB: assert property (
		state_reg.ctrl.ssel && !state_reg.ctrl.div
		&& !state_reg.ctrl.hold && sclk_rise && !wr2
		|=> cnt2 == 8'($past(cnt2) + 8'd1))
		else $error("second counter missed a subsystem edge");

	AST_CNT2_HOLD: assert property (
		state_reg.ctrl.hold && !wr2 |=> $stable(cnt2))
		else $error("second counter moved while held");

	AST_LOAD: assert property (
		wr1 || wr2
		|=> (!$past(wr1) || cnt1 == $past(pwdata_i[7:0]))
		 && (!$past(wr2) || cnt2 == $past(pwdata_i[7:0])))
		else $error("counter write not loaded at once");

	AST_CASCADE: assert property (
		state_reg.ctrl.div && !state_reg.ctrl.hold && aclk_rise
		&& cnt1 == CNT_FULL && !wr1 && !wr2
		|=> cnt1 == 8'h00 && cnt2 == 8'($past(cnt2) + 8'd1))
		else $error("cascade wrap did not advance second counter");

	AST_CASC_QUIET: assert property (
		state_reg.ctrl.div && !(aclk_rise && cnt1 == CNT_FULL) && !wr2
		|=> $stable(cnt2))
		else $error("second counter moved without a wrap in cascade");

	AST_FLAG_SET: assert property (
		interval_evt |=> interval_flag_o)
		else $error("interval flag not set");

	AST_IRQ_GATE: assert property (
		interval_irq_o |-> interval_flag_o && state_reg.ien
		&& $past(global_irq_enable_i))
		else $error("interrupt request without both enables");

	AST_SERVICE: assert property (
		interval_flag_o && irq_serviced_i && !interval_evt && !wr_lane0
		|=> !interval_flag_o)
		else $error("interval flag not cleared by service");

	AST_TICK: assert property (
		frame_evt |=> lcd_frame_tick_o ##1 !lcd_frame_tick_o)
		else $error("frame tick not a one-cycle pulse");

	AST_PREADY: assert property (
		psel_i && !penable_i && state_reg.apb_st == APB_IDLE
		|=> pready_o ##1 !pready_o)
		else $error("apb answer not in the access cycle");

	COV_CASCADE: cover property (casc_pulse && state_reg.ctrl.div);
	COV_FLAG:    cover property (interval_evt ##[1:4] interval_irq_o);
	COV_TICK:    cover property (lcd_frame_tick_o);
	COV_LOAD:    cover property (wr1 && inc1);

endmodule // dcit_timer

// File: sim/dcit_lcd_cpu_model.sv
// Purpose: LCD controller and CPU interrupt side facing the timer
// Assumes: Frame tick and irq arrive in the clock_i domain
// Notes:   Service is a one-cycle pulse, re-armed once it drops

`timescale 1ns/10ps

module dcit_lcd_cpu_model (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	// Timer outputs
	input  wire logic       lcd_frame_tick_i,
	input  wire logic       interval_irq_i,
	// Bench control
	input  wire logic       cpu_irq_enable_i,
	input  wire logic       service_en_i,
	// Timer inputs and status
	output logic            global_irq_enable_o,
	output logic            irq_serviced_o,
	output logic      [7:0] tick_count_o
);
	assign global_irq_enable_o = cpu_irq_enable_i;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			irq_serviced_o <= 1'b0;
			tick_count_o   <= 8'h00;
		end else begin
			// Timebase for common and segment drive
			tick_count_o <= tick_count_o + {7'h00, lcd_frame_tick_i};
			// Pulse only, so a stuck request is not hidden
			irq_serviced_o <= interval_irq_i & service_en_i
				& ~irq_serviced_o;
		end
	end
endmodule // dcit_lcd_cpu_model

// File: sim/dcit_timer_tb_top.sv
// Purpose: Self-checking bench for the dual cascadable interval timer
// Assumes: Counter clock pins are driven here and stand still between bursts
// Notes:   Each test programs every register it relies on first

`timescale 1ns/10ps

module dcit_timer_tb_top
	import dcit_pkg::*;
;
	logic              clk;
	logic              rst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              aux;
	logic              sub;
	logic [3:0]        pstrb;
	logic              cpu_irq_enable;
	logic              global_irq_enable;
	logic              svc_en;
	logic              svc;
	logic              flag;
	logic              irq;
	logic              tick;
	logic [7:0]        ticks;
	logic [7:0]        rv;
	logic              err;
	int                num_errors;
	int                n_tests;

	dcit_timer i_dcit_timer (
		.clock_i            (clk),
		.rst_i              (rst),
		.psel_i             (psel),
		.penable_i          (penable),
		.pwrite_i           (pwrite),
		.paddr_i            (paddr),
		.pwdata_i           (pwdata),
		.pstrb_i            (pstrb),
		.prdata_o           (prdata),
		.pready_o           (pready),
		.pslverr_o          (pslverr),
		.aux_clock_i        (aux),
		.subsystem_clock_i  (sub),
		.global_irq_enable_i(global_irq_enable),
		.irq_serviced_i     (svc),
		.interval_flag_o    (flag),
		.interval_irq_o     (irq),
		.lcd_frame_tick_o   (tick)
	);

	dcit_lcd_cpu_model i_dcit_lcd_cpu_model (
		.clock_i            (clk),
		.rst_i              (rst),
		.lcd_frame_tick_i   (tick),
		.interval_irq_i     (irq),
		.cpu_irq_enable_i   (cpu_irq_enable),
		.service_en_i       (svc_en),
		.global_irq_enable_o(global_irq_enable),
		.irq_serviced_o     (svc),
		.tick_count_o       (ticks)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Request held until pready is sampled high; software writes bytes only
	task automatic apb(input logic w, input logic [3:0] s,
		input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		pstrb   <= s;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, 4'h1, a, d);
	endtask

	task automatic rc(input logic [11:0] a, input logic [7:0] exp,
		input string what);
		apb(1'b0, 4'h0, a, 8'h00);
		chk(what, exp, rv);
	endtask

	// Slow pin edges, then settle past the synchroniser latency
	task automatic pulses(input bit on_sub, input int n);
		repeat (n) begin
			repeat (4) @(posedge clk);
			if (on_sub)
				sub <= 1'b1;
			else
				aux <= 1'b1;
			repeat (4) @(posedge clk);
			if (on_sub)
				sub <= 1'b0;
			else
				aux <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask

	task automatic t_regs();
		wr(OFS_CTRL, 8'ha5);
		rc(OFS_CTRL, 8'ha5, "ctrl");
		apb(1'b1, 4'he, OFS_CTRL, 8'h00);
		rc(OFS_CTRL, 8'ha5, "ctrl no lane0");
		wr(OFS_CNT1, 8'h3c);
		rc(OFS_CNT1, 8'h3c, "cnt1 load");
		wr(OFS_CNT2, 8'hc3);
		rc(OFS_CNT2, 8'hc3, "cnt2 load");
		wr(OFS_IEN, 8'h80);
		rc(OFS_IEN, 8'h80, "ien");
		apb(1'b0, 4'h0, 12'h020, 8'h00);
		chk("unmapped err", 8'h01, {7'h00, err});
		chk("unmapped data", 8'h00, rv);
		$display("test regs done");
	endtask

	task automatic t_count();
		wr(OFS_CTRL, 8'h00);
		wr(OFS_CNT1, 8'h00);
		wr(OFS_CNT2, 8'h00);
		pulses(0, 7);
		rc(OFS_CNT1, 8'h07, "cnt1 aux");
		rc(OFS_CNT2, 8'h07, "cnt2 aux");
		wr(OFS_CTRL, 8'h80);
		pulses(1, 3);
		pulses(0, 2);
		rc(OFS_CNT1, 8'h09, "cnt1 aux only");
		rc(OFS_CNT2, 8'h0a, "cnt2 sub");
		wr(OFS_CTRL, 8'h40);
		pulses(0, 5);
		rc(OFS_CNT1, 8'h0e, "cnt1 hold");
		rc(OFS_CNT2, 8'h0a, "cnt2 hold");
		wr(OFS_CTRL, 8'h60);
		pulses(0, 5);
		rc(OFS_CNT1, 8'h0e, "cnt1 hold div");
		wr(OFS_CTRL, 8'ha0);
		wr(OFS_CNT1, 8'hfe);
		wr(OFS_CNT2, 8'h10);
		pulses(0, 3);
		rc(OFS_CNT1, 8'h01, "cascade low");
		rc(OFS_CNT2, 8'h11, "cascade high");
		wr(OFS_CTRL, 8'h20);
		pulses(1, 2);
		rc(OFS_CNT2, 8'h11, "cascade no sub");
		$display("test count done");
	endtask

	task automatic t_frame();
		logic [7:0] t0;
		for (int f = 0; f < 4; f++) begin
			wr(OFS_CTRL, {3'h0, f[1:0], 3'h0});
			wr(OFS_CNT1, 8'h00);
			t0 = ticks;
			pulses(0, 256);
			chk("frame ticks", 8'h01 << f, ticks - t0);
		end
		$display("test frame done");
	endtask

	task automatic t_interval();
		wr(OFS_IEN, 8'h00);
		for (int ip = 0; ip < 8; ip++) begin
			wr(OFS_CTRL, {5'h10, ip[2:0]});
			wr(OFS_CNT2, 8'h00);
			wr(OFS_FLAG, 8'h00);
			pulses(1, (2 << ip) - 1);
			rc(OFS_FLAG, 8'h00, "flag early");
			pulses(1, 1);
			rc(OFS_FLAG, 8'h80, "flag set");
		end
		chk("flag pin", 8'h01, {7'h00, flag});
		$display("test interval done");
	endtask

	task automatic t_irq();
		wr(OFS_FLAG, 8'h80);
		wr(OFS_IEN, 8'h00);
		cpu_irq_enable <= 1'b1;
		repeat (3) @(posedge clk);
		chk("irq no ien", 8'h00, {7'h00, irq});
		cpu_irq_enable <= 1'b0;
		wr(OFS_IEN, 8'h80);
		repeat (3) @(posedge clk);
		chk("irq no global", 8'h00, {7'h00, irq});
		cpu_irq_enable <= 1'b1;
		repeat (3) @(posedge clk);
		chk("irq both", 8'h01, {7'h00, irq});
		svc_en <= 1'b1;
		repeat (4) @(posedge clk);
		rc(OFS_FLAG, 8'h00, "flag serviced");
		chk("irq serviced", 8'h00, {7'h00, irq});
		svc_en <= 1'b0;
		$display("test irq done");
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		aux = 1'b0;
		sub = 1'b0;
		pstrb = 4'h0;
		cpu_irq_enable = 1'b0;
		svc_en = 1'b0;
		num_errors = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_count();
		t_frame();
		t_interval();
		t_irq();
		tally_and_finish();
	end

	// Tests need about 13000 cycles; over four times that means a hang
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		$display("Error watchdog expired");
		tally_and_finish();
	end
endmodule // dcit_timer_tb_top
